// ===== core/timer_port_pkg.sv
package timer_port_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [15:0] OFF_DATA0 = 16'hf040;
    localparam logic [15:0] OFF_DATA1 = 16'hf041;
    localparam logic [15:0] OFF_DATA2 = 16'hf042;
    localparam logic [15:0] OFF_CMD = 16'hf043;
    localparam logic [7:0] CMD_RESET = 8'h00;

    // ------------------------------------------------------------
    // Command byte fields
    // ------------------------------------------------------------
    localparam int PICK_MSB = 7;
    localparam int PICK_LSB = 6;
    localparam int ACC_MSB = 5;
    localparam int ACC_LSB = 4;
    localparam int MODE_MSB = 3;
    localparam int MODE_LSB = 1;
    localparam int FMT_BIT = 0;
    localparam int RB_COUNT_N = 5;
    localparam int RB_STATUS_N = 4;
    localparam int RB_PICK_LSB = 1;

    localparam logic [1:0] PICK_READBACK = 2'h3;
    localparam logic [1:0] ACC_LATCH = 2'h0;
    localparam logic [1:0] ACC_LO = 2'h1;
    localparam logic [1:0] ACC_HI = 2'h2;
    localparam logic [1:0] ACC_BOTH = 2'h3;

    // ------------------------------------------------------------
    // Reset values of the per-counter programming
    // ------------------------------------------------------------
    localparam logic [1:0] ACC_RESET = ACC_BOTH;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic FMT_RESET = 1'b0;

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] acc;
        logic [2:0] mode;
        logic bcd;
        logic wr_hi;
        logic rd_hi;
        logic [7:0] wr_lo;
        logic cnt_held;
        logic [15:0] cnt_hold;
        logic sts_held;
        logic [7:0] sts_hold;
        logic pending;
        logic [15:0] load_val;
        logic load_stb;
        logic ctrl_stb;
    } chan_type;

    typedef struct packed {
        chan_type [2:0] ch;
        logic [7:0] rdata;
    } state_type;

endpackage

// ===== core/timer_command_readback_port.sv
`timescale 1ns/1ps

module timer_command_readback_port
    import timer_port_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int COUNT_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,

    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,

    // From the counting cores
    input wire logic [2:0][COUNT_W-1:0] live_count,
    input wire logic [2:0] counter_out,
    input wire logic [2:0] count_loaded,

    // To the counting cores
    output logic [2:0][COUNT_W-1:0] count_value,
    output logic [2:0] count_write,
    output logic [2:0] ctrl_write,
    output logic [2:0][2:0] operating_mode_field,
    output logic [2:0] count_format_bit
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    state_type s_q;
    state_type s_d;

    // Modes 2 and 3 come in two spellings; hand the cores one
    function automatic logic [2:0] norm_mode(input logic [2:0] m);
        begin
            norm_mode = m[1] ? {1'b0, m[1:0]} : m;
        end
    endfunction

    // Status byte of one counter as it stands now
    function automatic logic [7:0] status_of(input chan_type c,
                                             input logic out_lvl);
        begin
            status_of = {out_lvl, c.pending, c.acc, c.mode, c.bcd};
        end
    endfunction

    // ------------------------------------------------------------
    // Decode of the command byte
    // ------------------------------------------------------------
    logic cmd_wr;
    logic [1:0] pick;
    logic [1:0] acc_f;
    logic [2:0] mode_f;
    logic fmt_f;
    logic rb_count_n;
    logic rb_status_n;
    logic [2:0] rb_pick;

    // Fields are split once and reused by every format
    assign cmd_wr = wr && (addr == ADDR_W'(OFF_CMD));
    assign pick = wdata[PICK_MSB:PICK_LSB];
    assign acc_f = wdata[ACC_MSB:ACC_LSB];
    assign mode_f = wdata[MODE_MSB:MODE_LSB];
    assign fmt_f = wdata[FMT_BIT];
    assign rb_count_n = wdata[RB_COUNT_N];
    assign rb_status_n = wdata[RB_STATUS_N];
    assign rb_pick = wdata[RB_PICK_LSB+2:RB_PICK_LSB];

    logic ctrl_cmd;
    logic rb_cmd;

    // Top field 11 turns the whole byte into a read-back request;
    // anything else addresses one counter by its number
    assign ctrl_cmd = cmd_wr && (pick != PICK_READBACK);
    assign rb_cmd = cmd_wr && (pick == PICK_READBACK);

    // ------------------------------------------------------------
    // Data port decode
    // ------------------------------------------------------------
    logic [2:0] data_wr;
    logic [2:0] data_rd;

    // One strobe per counter; unmapped addresses raise none of them,
    // so a stray access can never move a byte pointer, and a read of
    // the command port answers zero
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            data_wr[i] = wr && (addr == ADDR_W'(OFF_DATA0 + 16'(i)));
            data_rd[i] = rd && (addr == ADDR_W'(OFF_DATA0 + 16'(i)));
        end
    end

    // ------------------------------------------------------------
    // Status bytes as they stand now
    // ------------------------------------------------------------
    logic [2:0][7:0] live_status;

    // Read-back copies this; the mode is echoed raw, not normalised,
    // and a status latched later sees the flags of its own cycle
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            live_status[i] = status_of(s_q.ch[i], counter_out[i]);
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // One pass per counter, and the order inside a pass is the priority:
    // the load acknowledge from the core comes first, so a count written
    // in the same cycle leaves the pending flag set. Reads and writes
    // never share a cycle, so their branches cannot fight.
    always_comb begin
        logic [COUNT_W-1:0] src;
        logic [7:0] byte_out;
        logic done;
        s_d = s_q;
        src = '0;
        byte_out = 8'h00;
        done = 1'b0;
        // Read data stand only in the cycle after the read
        s_d.rdata = 8'h00;

        for (int i = 0; i < 3; i++) begin
            // Strobes to the cores last one cycle
            s_d.ch[i].load_stb = 1'b0;
            s_d.ch[i].ctrl_stb = 1'b0;
            // Core took the count; a write later in this pass wins
            if (count_loaded[i]) begin
                s_d.ch[i].pending = 1'b0;
            end

            // Command port: counter-addressed formats
            if (ctrl_cmd && pick == 2'(i)) begin
                if (acc_f == ACC_LATCH) begin
                    // Only the first latch command counts
                    if (!s_q.ch[i].cnt_held) begin
                        // The core keeps counting; only this copy freezes
                        s_d.ch[i].cnt_held = 1'b1;
                        s_d.ch[i].cnt_hold = 16'(live_count[i]);
                    end
                end else begin
                    // Control word: reprogram, drop latches, reset order.
                    // Software that lost track of a half-done read can
                    // recover by programming the counter again.
                    s_d.ch[i].acc = acc_f;
                    s_d.ch[i].mode = mode_f;
                    s_d.ch[i].bcd = fmt_f;
                    s_d.ch[i].wr_hi = 1'b0;
                    s_d.ch[i].rd_hi = 1'b0;
                    s_d.ch[i].cnt_held = 1'b0;
                    s_d.ch[i].sts_held = 1'b0;
                    s_d.ch[i].ctrl_stb = 1'b1;
                end
            end

            // Command port: read-back format
            if (rb_cmd && rb_pick[i]) begin
                // Count and status are kept apart, so one may land while
                // the other is already held and stays as it was
                if (!rb_count_n && !s_q.ch[i].cnt_held) begin
                    s_d.ch[i].cnt_held = 1'b1;
                    s_d.ch[i].cnt_hold = 16'(live_count[i]);
                end
                if (!rb_status_n && !s_q.ch[i].sts_held) begin
                    s_d.ch[i].sts_held = 1'b1;
                    s_d.ch[i].sts_hold = live_status[i];
                end
            end

            // Data port write: mode is left as programmed
            if (data_wr[i]) begin
                case (s_q.ch[i].acc)
                    ACC_LO: begin
                        s_d.ch[i].load_val = {8'h00, wdata};
                        s_d.ch[i].load_stb = 1'b1;
                        s_d.ch[i].pending = 1'b1;
                    end
                    ACC_HI: begin
                        s_d.ch[i].load_val = {wdata, 8'h00};
                        s_d.ch[i].load_stb = 1'b1;
                        s_d.ch[i].pending = 1'b1;
                    end
                    ACC_BOTH: begin
                        // Write order runs apart from read order
                        if (s_q.ch[i].wr_hi) begin
                            s_d.ch[i].load_val = {wdata,
                                                  s_q.ch[i].wr_lo};
                            s_d.ch[i].load_stb = 1'b1;
                            s_d.ch[i].pending = 1'b1;
                        end else begin
                            s_d.ch[i].wr_lo = wdata;
                        end
                        s_d.ch[i].wr_hi = !s_q.ch[i].wr_hi;
                    end
                    default: begin
                        s_d.ch[i].wr_hi = 1'b0;
                    end
                endcase
            end

            // Data port read: status, then latched count, then live
            if (data_rd[i]) begin
                if (s_q.ch[i].sts_held) begin
                    s_d.rdata = s_q.ch[i].sts_hold;
                    s_d.ch[i].sts_held = 1'b0;
                end else begin
                    // Live count is only stable with the gate low; the
                    // block cannot tell, so an unlatched read is only as
                    // good as the software that stopped the counter
                    src = s_q.ch[i].cnt_held ? COUNT_W'(s_q.ch[i].cnt_hold)
                                             : live_count[i];
                    case (s_q.ch[i].acc)
                        ACC_LO: begin
                            byte_out = src[7:0];
                            done = 1'b1;
                        end
                        ACC_HI: begin
                            byte_out = src[15:8];
                            done = 1'b1;
                        end
                        ACC_BOTH: begin
                            byte_out = s_q.ch[i].rd_hi ? src[15:8]
                                                       : src[7:0];
                            done = s_q.ch[i].rd_hi;
                            s_d.ch[i].rd_hi = !s_q.ch[i].rd_hi;
                        end
                        default: begin
                            byte_out = 8'h00;
                            done = 1'b0;
                        end
                    endcase
                    s_d.rdata = byte_out;
                    // Release the latch once all bytes are out
                    if (done) begin
                        s_d.ch[i].cnt_held = 1'b0;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Async reset; only the access field comes out non-zero, so a
    // counter reads back as lo-then-hi, mode 0, binary, while the
    // strobes and the read data come out low
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            for (int i = 0; i < 3; i++) begin
                s_q.ch[i].acc <= ACC_RESET;
                s_q.ch[i].mode <= MODE_RESET;
                s_q.ch[i].bcd <= FMT_RESET;
            end
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Read data come straight from flip-flops
    assign rdata = s_q.rdata;

    // Core-facing outputs; the mode is normalised here, not in the state
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            count_value[i] = COUNT_W'(s_q.ch[i].load_val);
            count_write[i] = s_q.ch[i].load_stb;
            ctrl_write[i] = s_q.ch[i].ctrl_stb;
            operating_mode_field[i] = norm_mode(s_q.ch[i].mode);
            count_format_bit[i] = s_q.ch[i].bcd;
        end
    end

endmodule

// ===== bench/port_checker.sv
`timescale 1ns/1ps

// ----
// Protocol checker
// ----
module port_checker
    import timer_port_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // To the cores
    input wire logic [2:0] count_write,
    input wire logic [2:0] ctrl_write,
    input wire logic [2:0][2:0] operating_mode_field,
    input wire logic [2:0] count_format_bit
);
    // Command decode; counter 0 stands in for all three
    wire cmd = wr && addr == OFF_CMD;
    wire cw0 = cmd && wdata[7:6] == 2'h0 && wdata[5:4] != ACC_LATCH;
    wire dw = wr && addr inside {OFF_DATA0, OFF_DATA1, OFF_DATA2};
    wire dw0 = wr && addr == OFF_DATA0;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    a_ctrl_pulse: assert property (cw0 |=> ctrl_write == 3'h1)
        else $error("control word pulse wrong");
    a_rb_quiet: assert property (
        cmd && wdata[7:6] == PICK_READBACK |=> ctrl_write == 3'h0)
        else $error("read-back reprogrammed a counter");
    a_latch_quiet: assert property (
        cmd && wdata[5:4] == ACC_LATCH |=> ctrl_write == 3'h0)
        else $error("latch reprogrammed a counter");
    a_mode_low: assert property (
        cw0 |=> operating_mode_field[0][1:0] == $past(wdata[2:1]))
        else $error("mode bits wrong");
    a_mode_top: assert property (
        cw0 && wdata[2] |=> !operating_mode_field[0][2])
        else $error("mode top bit not ignored");
    a_fmt_echo: assert property (
        cw0 |=> count_format_bit[0] == $past(wdata[0]))
        else $error("count format wrong");
    a_mode_kept: assert property (
        dw |=> $stable(operating_mode_field) && ctrl_write == 3'h0)
        else $error("count write changed the mode");
    a_write_cause: assert property (
        count_write[0] |-> $past(dw0))
        else $error("count write without data write");
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside read answer");

    c_ctrl: cover property (cw0);
    c_latch: cover property (cmd && wdata == 8'h00);
    c_rb: cover property (cmd && wdata[7:6] == PICK_READBACK);
endmodule

bind timer_command_readback_port port_checker #(.ADDR_W(ADDR_W)) chk_i (.*);

// ===== bench/tb_timer_command_readback_port.sv
`timescale 1ns/1ps

// ----
// Bench
// ----
module tb_timer_command_readback_port
    import timer_port_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] addr = 16'h0;
    logic [7:0] wdata = 8'h0;
    logic [7:0] rdata;
    logic [2:0][15:0] live_count = 48'h0;
    logic [2:0][15:0] count_value;
    logic [2:0] counter_out = 3'h0;
    logic [2:0] count_loaded = 3'h0;
    logic [2:0] count_write, ctrl_write, count_format_bit;
    logic [2:0][2:0] operating_mode_field;
    int n_errors = 0;
    int comparisons = 0;

    timer_command_readback_port uut (
        .clk(clk),
        .reset(reset),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .live_count(live_count),
        .counter_out(counter_out),
        .count_loaded(count_loaded),
        .count_value(count_value),
        .count_write(count_write),
        .ctrl_write(ctrl_write),
        .operating_mode_field(operating_mode_field),
        .count_format_bit(count_format_bit)
    );

    initial forever #5 clk = ~clk;

    task automatic chk(input string nm, input logic [15:0] s, e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    endtask

    // One-cycle bus cycles; wr8 returns at the sampling edge, rd8 checks and returns 1 ns after it
    task automatic wr8(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd8(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", rdata, e);
    endtask

    task automatic stop_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic t_reset;
        chk("mode", operating_mode_field, 9'h0);
        chk("fmt", count_format_bit, 3'h0);
        wr8(OFF_CMD, 8'he2);
        rd8(OFF_DATA0, 8'h30);
    endtask

    // Every mode code and format, echoed raw in status
    task automatic t_modes;
        logic [2:0] m;
        logic [2:0] e;
        @(posedge clk);
        counter_out <= 3'h2;
        for (int i = 0; i < 16; i++) begin
            m = i[3:1];
            e = m == 3'h6 ? 3'h2 : (m == 3'h7 ? 3'h3 : m);
            wr8(OFF_CMD, {4'h5, i[3:0]});
            #1 chk("ctrl", ctrl_write, 3'h2);
            chk("mode", operating_mode_field[1], e);
            chk("fmt", count_format_bit[1], i[0]);
            wr8(OFF_CMD, 8'he4);
            rd8(OFF_DATA1, {4'h9, i[3:0]});
        end
    endtask

    task automatic t_walk;
        wr8(OFF_CMD, 8'h34);
        #1 chk("ctrl", ctrl_write, 3'h1);
        wr8(OFF_DATA0, 8'h10);
        #1 chk("cwr", count_write, 3'h0);
        wr8(OFF_DATA0, 8'h27);
        #1 chk("cwr", count_write, 3'h1);
        chk("pick_channel_zero", count_value[0], 16'h2710);
        chk("mode0", operating_mode_field[0], 3'h2);
        wr8(OFF_CMD, 8'he2);
        rd8(OFF_DATA0, 8'h74);
        @(posedge clk);
        count_loaded <= 3'h1;
        @(posedge clk);
        count_loaded <= 3'h0;
        wr8(OFF_CMD, 8'he2);
        rd8(OFF_DATA0, 8'h34);
        wr8(OFF_DATA1, 8'h5a);
        #1 chk("pick_channel_one", count_value[1], 16'h005a);
        wr8(OFF_CMD, 8'h60);
        wr8(OFF_DATA1, 8'ha5);
        #1 chk("pick_channel_one", count_value[1], 16'ha500);
    endtask

    // Latch held against a repeat; reads and writes interleaved
    task automatic t_latch;
        @(posedge clk);
        live_count[0] <= 16'h1234;
        wr8(OFF_CMD, 8'h00);
        live_count[0] <= 16'h5678;
        wr8(OFF_CMD, 8'h00);
        rd8(OFF_DATA0, 8'h34);
        wr8(OFF_DATA0, 8'haa);
        rd8(OFF_DATA0, 8'h12);
        wr8(OFF_DATA0, 8'hbb);
        #1 chk("pick_channel_zero", count_value[0], 16'hbbaa);
        rd8(OFF_DATA0, 8'h78);
        rd8(OFF_DATA0, 8'h56);
    endtask

    // Count then status latched; repeats ignored; status read first
    task automatic t_readback;
        @(posedge clk);
        live_count[2] <= 16'h0102;
        live_count[1] <= 16'hc300;
        wr8(OFF_CMD, 8'hd8);
        live_count[2] <= 16'h0304;
        wr8(OFF_CMD, 8'he8);
        wr8(OFF_CMD, 8'hc9);
        rd8(OFF_DATA1, 8'hc3);
        rd8(OFF_DATA2, 8'h30);
        rd8(OFF_DATA2, 8'h02);
        rd8(OFF_DATA2, 8'h01);
        rd8(OFF_DATA2, 8'h04);
        rd8(OFF_DATA2, 8'h03);
        rd8(OFF_CMD, 8'h00);
        rd8(16'hf044, 8'h00);
        // Reprogramming drops a latch that was never read
        wr8(OFF_CMD, 8'h80);
        live_count[2] <= 16'h0506;
        wr8(OFF_CMD, 8'h98);
        #1 chk("ctrl", ctrl_write, 3'h4);
        chk("mode2", operating_mode_field[2], 3'h4);
        rd8(OFF_DATA2, 8'h06);
    endtask

    // Mid-run reset puts the programming back to its reset values
    task automatic t_again;
        wr8(OFF_CMD, 8'h1b);
        #1 chk("mode0", operating_mode_field[0], 3'h5);
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        #1 chk("mode0", operating_mode_field[0], 3'h0);
        chk("fmt0", count_format_bit[0], 1'b0);
        @(posedge clk);
        reset <= 1'b0;
        wr8(OFF_CMD, 8'he2);
        rd8(OFF_DATA0, 8'h30);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_reset;
        t_modes;
        t_walk;
        t_latch;
        t_readback;
        t_again;
        stop_test;
    end

    // Hang guard
    initial begin
        #200000;
        n_errors++;
        stop_test;
    end
endmodule
